//--- design/twm_defines.vh
// Register map, field positions and constants of the waveform mode control block
//
// Behaviour
// [RQ1] Nonzero output mode routes wave to pin
// [RQ2] Pin driven only when direction bit set
// [RQ3] Non-PWM: disconnect, toggle, clear, set on match
// [RQ4] Fast PWM: 2 non-inverting, 3 inverting
// [RQ5] Mode 1: toggle A only when bit3 set
// [RQ6] Fast PWM: match at TOP ignored, BOTTOM acts
// [RQ7] Phase correct: clear up, set down, or opposite
// [RQ8] Mode 0000 normal, TOP 0xFFFF
// [RQ9] 0100/1100 CTC with A or capture TOP
// [RQ10] 0001-0011 phase correct fixed TOP
// [RQ11] Fast PWM codes; 1101 reserved
// [RQ12] 1000/1001 phase-frequency correct, update BOTTOM
// [RQ13] 1010/1011 phase correct, update TOP
// [RQ14] Mode from regA 1:0 and regB 4:3
// [RQ15] Noise filter needs four equal samples
// [RQ16] Edge select: 0 falling, 1 rising
// [RQ17] Capture copies counter, sets flag
// [RQ18] Capture TOP disables capture input
// [RQ19] Software writes zero to regB bit 5
// [RQ20] Reg A resets zero, bits 3:2 read zero
// [RQ21] Capture pin synchronised before filtering
`ifndef TWM_DEFINES_VH
`define TWM_DEFINES_VH

// Printed offset is not word aligned: kept as an index, byte address is four times it
`define TWM_IDX_CTRL_A     10'h02e
`define TWM_ADDR_CTRL_A    {`TWM_IDX_CTRL_A, 2'b00}
`define TWM_ADDR_CTRL_B    12'h030
`define TWM_ADDR_STATUS    12'h034
`define TWM_ADDR_CAPTURE   12'h038
`define TWM_ADDR_COUNTER   12'h03c
`define TWM_ADDR_CMP_A     12'h040
`define TWM_ADDR_CMP_B     12'h044

`define TWM_CTRL_A_RESET   8'h00
`define TWM_CTRL_B_RESET   8'h00
`define TWM_CTRL_A_WMASK   8'hf3
`define TWM_CTRL_B_WMASK   8'hd8

`define TWM_A_MODE_HI      7
`define TWM_A_MODE_LO      6
`define TWM_B_MODE_HI      5
`define TWM_B_MODE_LO      4
`define TWM_WAVE_LOW_HI    1
`define TWM_WAVE_LOW_LO    0
`define TWM_FILTER_EN_BIT  7
`define TWM_EDGE_SEL_BIT   6
`define TWM_WAVE_HIGH_HI   4
`define TWM_WAVE_HIGH_LO   3
`define TWM_STAT_CAPT_BIT  0
`define TWM_STAT_OVF_BIT   1

`define TWM_TOP_MAX        16'hffff
`define TWM_TOP_8BIT       16'h00ff
`define TWM_TOP_9BIT       16'h01ff
`define TWM_TOP_10BIT      16'h03ff

`define TWM_KIND_NORMAL    3'd0
`define TWM_KIND_CTC       3'd1
`define TWM_KIND_FAST      3'd2
`define TWM_KIND_PHASE     3'd3
`define TWM_KIND_PFC       3'd4
`define TWM_KIND_RSVD      3'd5

`define TWM_TOPSRC_FIXED   2'd0
`define TWM_TOPSRC_CMPA    2'd1
`define TWM_TOPSRC_CAPT    2'd2

`define TWM_AT_IMMEDIATE   2'd0
`define TWM_AT_TOP         2'd1
`define TWM_AT_BOTTOM      2'd2
`define TWM_AT_MAX         2'd3

`define TWM_FILTER_SAMPLES 4

`endif

//--- design/twm_capture_filter.v
// Capture pin synchroniser, noise filter and edge detector
`timescale 1ns/10ps
`include "twm_defines.vh"
module twm_capture_filter #(
   parameter SAMPLES = `TWM_FILTER_SAMPLES
) (
   input  wire clk,
   input  wire resetn,
   input  wire capturePin,
   input  wire filterEn,
   input  wire edgeSelect,
   input  wire enable,
   output reg  captureEvent
);
   reg       syncStage1;
   reg       syncStage2;
   reg [SAMPLES-1:0] history;
   reg       filtered;
   reg       prevLevel;
   wire      allHigh = &history;
   wire      allLow  = ~|history;
   wire      level   = filterEn ? filtered : syncStage2;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         syncStage1   <= 1'b0;
         syncStage2   <= 1'b0;
         history      <= {SAMPLES{1'b0}};
         filtered     <= 1'b0;
         prevLevel    <= 1'b0;
         captureEvent <= 1'b0;
      end else begin
         syncStage1 <= capturePin; // RQ21
         syncStage2 <= syncStage1; // RQ21
         history    <= {history[SAMPLES-2:0], syncStage2};
         if (allHigh) begin
            filtered <= 1'b1; // RQ15
         end else if (allLow) begin
            filtered <= 1'b0; // RQ15
         end
         prevLevel <= level;
         // Rising when edgeSelect set, falling otherwise
         captureEvent <= enable & (edgeSelect ? (level & ~prevLevel)
                                              : (~level & prevLevel)); // RQ16 RQ18
      end
   end
endmodule // twm_capture_filter

//--- design/twm_output_unit.v
// One compare channel: pin action decode and waveform output flip-flop
`timescale 1ns/10ps
`include "twm_defines.vh"
module twm_output_unit #(
   parameter IS_CHAN_A = 1
) (
   input  wire       clk,
   input  wire       resetn,
   input  wire [1:0] outputMode,
   input  wire [2:0] modeKind,
   input  wire       modeBit3,
   input  wire       match,
   input  wire       matchAtTop,
   input  wire       atBottom,
   input  wire       countingDown,
   input  wire       dirOut,
   output wire       pinOut,
   output wire       pinOe,
   output wire       connected
);
   reg  wave;
   reg  next_wave;
   wire isPwm     = (modeKind == `TWM_KIND_FAST) || (modeKind == `TWM_KIND_PHASE) ||
                    (modeKind == `TWM_KIND_PFC);
   wire toggleOk  = !isPwm || (modeBit3 && (IS_CHAN_A != 0)); // RQ5
   wire useMatch  = match && !((modeKind == `TWM_KIND_FAST) && outputMode[1] &&
                    matchAtTop); // RQ6

   assign connected = (outputMode == 2'd1) ? toggleOk : (outputMode != 2'd0); // RQ1 RQ5
   assign pinOe     = connected & dirOut; // RQ2
   assign pinOut    = wave;

   always @* begin
      next_wave = wave;
      case (modeKind)
         `TWM_KIND_FAST: begin
            if (outputMode[1] && atBottom) begin
               next_wave = ~outputMode[0]; // RQ4
            end
            if (useMatch) begin
               if (outputMode == 2'd1) begin
                  next_wave = wave ^ toggleOk; // RQ5
               end else if (outputMode[1]) begin
                  next_wave = outputMode[0]; // RQ4
               end
            end
         end
         `TWM_KIND_PHASE, `TWM_KIND_PFC: begin
            if (useMatch) begin
               if (outputMode == 2'd1) begin
                  next_wave = wave ^ toggleOk; // RQ5
               end else if (outputMode[1]) begin
                  next_wave = outputMode[0] ^ countingDown; // RQ7
               end
            end
         end
         `TWM_KIND_NORMAL, `TWM_KIND_CTC: begin
            if (match) begin
               case (outputMode)
                  2'd1:    next_wave = ~wave; // RQ3
                  2'd2:    next_wave = 1'b0; // RQ3
                  2'd3:    next_wave = 1'b1; // RQ3
                  default: next_wave = wave;
               endcase
            end
         end
         default: next_wave = wave;
      endcase
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wave <= 1'b0;
      end else begin
         wave <= next_wave;
      end
   end
endmodule // twm_output_unit

//--- design/twm_mode_control.v
// Waveform mode control: APB registers, mode decode, output and capture units
`timescale 1ns/10ps
`include "twm_defines.vh"
module twm_mode_control (
   input  wire        clk,
   input  wire        resetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   input  wire [15:0] counterValue,
   input  wire [15:0] compareValueA,
   input  wire [15:0] compareValueB,
   input  wire        matchA,
   input  wire        matchB,
   input  wire        countingDown,
   input  wire        dirOutA,
   input  wire        dirOutB,
   input  wire        capturePin,
   output wire        chanAWaveOut,
   output wire        chanAWaveOe,
   output wire        chanBWaveOut,
   output wire        chanBWaveOe,
   output reg  [15:0] topValue,
   output reg  [2:0]  modeKind,
   output reg  [1:0]  compareUpdateAt,
   output reg  [1:0]  overflowAt,
   output reg  [15:0] captureRegister,
   output reg         captureFlag,
   output wire        captureEnabled,
   output reg         overflowFlag
);
   reg  [7:0]  waveformOutputControl;
   reg  [7:0]  captureAndModeControl;
   reg  [1:0]  topSource;
   reg  [15:0] fixedTop;
   wire [3:0]  waveformMode;
   wire        captureEvent;
   wire        apbWrite = psel & penable & pwrite;
   wire        apbRead  = psel & penable & ~pwrite;
   wire        atBottom = (counterValue == 16'h0000);
   wire        atTop    = (counterValue == topValue);
   wire        atMax    = (counterValue == `TWM_TOP_MAX);
   reg         ovfEvent;

   function mapped;
      input [11:0] addr;
      begin
         mapped = (addr == `TWM_ADDR_CTRL_A) || (addr == `TWM_ADDR_CTRL_B) ||
                  (addr == `TWM_ADDR_STATUS) || (addr == `TWM_ADDR_CAPTURE) ||
                  (addr == `TWM_ADDR_COUNTER) || (addr == `TWM_ADDR_CMP_A) ||
                  (addr == `TWM_ADDR_CMP_B);
      end
   endfunction

   function eventAt;
      input [1:0] point;
      input       top;
      input       bottom;
      input       max;
      begin
         case (point)
            `TWM_AT_TOP:    eventAt = top;
            `TWM_AT_BOTTOM: eventAt = bottom;
            `TWM_AT_MAX:    eventAt = max;
            default:        eventAt = 1'b0;
         endcase
      end
   endfunction

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped(paddr);

   assign waveformMode = {captureAndModeControl[`TWM_WAVE_HIGH_HI:`TWM_WAVE_HIGH_LO],
                          waveformOutputControl[`TWM_WAVE_LOW_HI:`TWM_WAVE_LOW_LO]}; // RQ14

   // Mode table
   always @* begin
      modeKind        = `TWM_KIND_RSVD;
      topSource       = `TWM_TOPSRC_FIXED;
      fixedTop        = `TWM_TOP_MAX;
      compareUpdateAt = `TWM_AT_IMMEDIATE;
      overflowAt      = `TWM_AT_MAX;
      case (waveformMode)
         4'b0000: begin
            modeKind = `TWM_KIND_NORMAL; // RQ8
         end
         4'b0100: begin
            modeKind  = `TWM_KIND_CTC; // RQ9
            topSource = `TWM_TOPSRC_CMPA;
         end
         4'b1100: begin
            modeKind  = `TWM_KIND_CTC; // RQ9
            topSource = `TWM_TOPSRC_CAPT;
         end
         4'b0001, 4'b0010, 4'b0011: begin
            modeKind        = `TWM_KIND_PHASE; // RQ10
            compareUpdateAt = `TWM_AT_TOP;
            overflowAt      = `TWM_AT_BOTTOM;
         end
         4'b0101, 4'b0110, 4'b0111: begin
            modeKind        = `TWM_KIND_FAST; // RQ11
            compareUpdateAt = `TWM_AT_TOP;
            overflowAt      = `TWM_AT_TOP;
         end
         4'b1110, 4'b1111: begin
            modeKind        = `TWM_KIND_FAST; // RQ11
            topSource       = waveformMode[0] ? `TWM_TOPSRC_CMPA : `TWM_TOPSRC_CAPT;
            compareUpdateAt = `TWM_AT_TOP;
            overflowAt      = `TWM_AT_TOP;
         end
         4'b1000, 4'b1001: begin
            modeKind        = `TWM_KIND_PFC; // RQ12
            topSource       = waveformMode[0] ? `TWM_TOPSRC_CMPA : `TWM_TOPSRC_CAPT;
            compareUpdateAt = `TWM_AT_BOTTOM;
            overflowAt      = `TWM_AT_BOTTOM;
         end
         4'b1010, 4'b1011: begin
            modeKind        = `TWM_KIND_PHASE; // RQ13
            topSource       = waveformMode[0] ? `TWM_TOPSRC_CMPA : `TWM_TOPSRC_CAPT;
            compareUpdateAt = `TWM_AT_TOP;
            overflowAt      = `TWM_AT_BOTTOM;
         end
         default: begin
            modeKind = `TWM_KIND_RSVD; // RQ11
         end
      endcase
      // Fixed widths share low bits across phase correct and fast PWM
      case (waveformMode)
         4'b0001, 4'b0101: fixedTop = `TWM_TOP_8BIT; // RQ10 RQ11
         4'b0010, 4'b0110: fixedTop = `TWM_TOP_9BIT; // RQ10 RQ11
         4'b0011, 4'b0111: fixedTop = `TWM_TOP_10BIT; // RQ10 RQ11
         default:          fixedTop = `TWM_TOP_MAX; // RQ8
      endcase
      case (topSource)
         `TWM_TOPSRC_CMPA: topValue = compareValueA;
         `TWM_TOPSRC_CAPT: topValue = captureRegister;
         default:          topValue = fixedTop;
      endcase
      ovfEvent = eventAt(overflowAt, atTop, atBottom, atMax);
   end

   assign captureEnabled = (topSource != `TWM_TOPSRC_CAPT); // RQ18

   // Registers
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         waveformOutputControl <= `TWM_CTRL_A_RESET; // RQ20
         captureAndModeControl <= `TWM_CTRL_B_RESET;
      end else if (apbWrite) begin
         if (paddr == `TWM_ADDR_CTRL_A) begin
            waveformOutputControl <= pwdata[7:0] & `TWM_CTRL_A_WMASK; // RQ20
         end
         if (paddr == `TWM_ADDR_CTRL_B) begin
            captureAndModeControl <= pwdata[7:0] & `TWM_CTRL_B_WMASK; // RQ19
         end
      end
   end

   // Capture and overflow; hardware set wins over software clear
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         captureRegister <= 16'h0000;
         captureFlag     <= 1'b0;
         overflowFlag    <= 1'b0;
      end else begin
         if (captureEvent) begin
            captureRegister <= counterValue; // RQ17
         end else if (apbWrite && paddr == `TWM_ADDR_CAPTURE && !captureEnabled) begin
            captureRegister <= pwdata[15:0];
         end
         if (captureEvent || (!captureEnabled && atTop)) begin
            captureFlag <= 1'b1; // RQ17
         end else if (apbWrite && paddr == `TWM_ADDR_STATUS &&
                      pwdata[`TWM_STAT_CAPT_BIT]) begin
            captureFlag <= 1'b0;
         end
         if (ovfEvent) begin
            overflowFlag <= 1'b1;
         end else if (apbWrite && paddr == `TWM_ADDR_STATUS &&
                      pwdata[`TWM_STAT_OVF_BIT]) begin
            overflowFlag <= 1'b0;
         end
      end
   end

   always @* begin
      prdata = 32'h00000000;
      if (apbRead) begin
         case (paddr)
            `TWM_ADDR_CTRL_A:  prdata = {24'h000000, waveformOutputControl};
            `TWM_ADDR_CTRL_B:  prdata = {24'h000000, captureAndModeControl};
            `TWM_ADDR_STATUS:  prdata = {30'h00000000, overflowFlag, captureFlag};
            `TWM_ADDR_CAPTURE: prdata = {16'h0000, captureRegister};
            `TWM_ADDR_COUNTER: prdata = {16'h0000, counterValue};
            `TWM_ADDR_CMP_A:   prdata = {16'h0000, compareValueA};
            `TWM_ADDR_CMP_B:   prdata = {16'h0000, compareValueB};
            default:           prdata = 32'h00000000;
         endcase
      end
   end

   twm_capture_filter u_capture (
      .clk          (clk),
      .resetn       (resetn),
      .capturePin   (capturePin),
      .filterEn     (captureAndModeControl[`TWM_FILTER_EN_BIT]),
      .edgeSelect   (captureAndModeControl[`TWM_EDGE_SEL_BIT]),
      .enable       (captureEnabled),
      .captureEvent (captureEvent)
   );

   twm_output_unit #(.IS_CHAN_A(1)) u_chan_a (
      .clk          (clk),
      .resetn       (resetn),
      .outputMode   (waveformOutputControl[`TWM_A_MODE_HI:`TWM_A_MODE_LO]),
      .modeKind     (modeKind),
      .modeBit3     (waveformMode[3]),
      .match        (matchA),
      .matchAtTop   (compareValueA == topValue),
      .atBottom     (atBottom),
      .countingDown (countingDown),
      .dirOut       (dirOutA),
      .pinOut       (chanAWaveOut),
      .pinOe        (chanAWaveOe),
      .connected    ()
   );

   twm_output_unit #(.IS_CHAN_A(0)) u_chan_b (
      .clk          (clk),
      .resetn       (resetn),
      .outputMode   (waveformOutputControl[`TWM_B_MODE_HI:`TWM_B_MODE_LO]),
      .modeKind     (modeKind),
      .modeBit3     (waveformMode[3]),
      .match        (matchB),
      .matchAtTop   (compareValueB == topValue),
      .atBottom     (atBottom),
      .countingDown (countingDown),
      .dirOut       (dirOutB),
      .pinOut       (chanBWaveOut),
      .pinOe        (chanBWaveOe),
      .connected    ()
   );
endmodule // twm_mode_control

//--- tb/twm_mode_control_properties.sv
// Port-level checks of the waveform mode control block
`timescale 1ns/10ps
`include "twm_defines.vh"
module twm_mode_control_props (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [15:0] counterValue,
   input wire logic [15:0] compareValueA,
   input wire logic        matchA,
   input wire logic        countingDown,
   input wire logic        dirOutA,
   input wire logic        dirOutB,
   input wire logic        capturePin,
   input wire logic        chanAWaveOut,
   input wire logic        chanAWaveOe,
   input wire logic        chanBWaveOe,
   input wire logic [15:0] topValue,
   input wire logic [2:0]  modeKind,
   input wire logic [1:0]  compareUpdateAt,
   input wire logic [1:0]  overflowAt,
   input wire logic [15:0] captureRegister,
   input wire logic        captureFlag,
   input wire logic        captureEnabled
);
   reg  [7:0] shA;
   reg  [7:0] shB;
   wire [3:0] wm     = {shB[4:3], shA[1:0]};
   wire [1:0] mA     = shA[7:6];
   wire [1:0] mB     = shA[5:4];
   wire       nonPwm = modeKind < 3'd2;
   wire       capSrc = wm[3] && !wm[0];
   wire       cmpSrc = (wm == 4'd4) || (wm[3] && wm[0]);

   // Shadow of the two control registers
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shA <= 8'h00;
         shB <= 8'h00;
      end else if (psel && penable && pwrite && paddr == `TWM_ADDR_CTRL_A) begin
         shA <= pwdata[7:0];
      end else if (psel && penable && pwrite && paddr == `TWM_ADDR_CTRL_B) begin
         shB <= pwdata[7:0];
      end
   end

   function automatic [2:0] kindOf(input [3:0] w);
      case (w)
         4'd0: kindOf = 3'd0;
         4'd4, 4'd12: kindOf = 3'd1;
         4'd5, 4'd6, 4'd7, 4'd14, 4'd15: kindOf = 3'd2;
         4'd8, 4'd9: kindOf = 3'd4;
         4'd13: kindOf = 3'd5;
         default: kindOf = 3'd3;
      endcase
   endfunction

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_trig;
      !shB[7] && captureEnabled && !captureFlag && (shB[6] ? $rose(capturePin) : $fell(capturePin));
   endsequence
   sequence s_match_a;
      matchA && mA[1] && counterValue != 16'h0000 && compareValueA != topValue;
   endsequence

   property p_mode_join;
      modeKind == kindOf(wm);
   endproperty
   property p_points;
      modeKind != 3'd5 |-> {compareUpdateAt, overflowAt} ==
         (modeKind == 3'd2 ? 4'h5 : modeKind == 3'd3 ? 4'h6 : modeKind == 3'd4 ? 4'ha : 4'h3);
   endproperty
   property p_top;
      wm != 4'd13 |-> captureEnabled == !capSrc && topValue == (capSrc ? captureRegister :
         cmpSrc ? compareValueA : wm == 4'd0 ? 16'hffff : (16'h0080 << wm[1:0]) - 16'h0001);
   endproperty
   property p_oe_a;
      modeKind != 3'd5 |-> chanAWaveOe == (dirOutA && mA != 2'd0 && (nonPwm || mA != 2'd1 || wm[3]));
   endproperty
   property p_oe_b;
      modeKind != 3'd5 |-> chanBWaveOe == (dirOutB && mB != 2'd0 && (nonPwm || mB != 2'd1));
   endproperty
   property p_nonpwm_a;
      nonPwm && matchA && mA != 2'd0 |=>
         chanAWaveOut == (mA == 2'd1 ? !$past(chanAWaveOut) : mA[0]);
   endproperty
   property p_fast_a;
      s_match_a ##0 modeKind == 3'd2 |=> chanAWaveOut == mA[0];
   endproperty
   property p_top_match;
      modeKind == 3'd2 && matchA && mA[1] && compareValueA == topValue && counterValue != 16'h0000
         |=> $stable(chanAWaveOut);
   endproperty
   property p_phase_a;
      s_match_a ##0 (modeKind == 3'd3 || modeKind == 3'd4) |=>
         chanAWaveOut == (mA[0] ^ $past(countingDown));
   endproperty
   property p_capture_edge;
      s_trig ##1 $stable(capturePin) [*3] |-> ##[1:4] captureFlag;
   endproperty
   property p_capture_copy;
      captureEnabled && $rose(captureFlag) |-> captureRegister == $past(counterValue);
   endproperty

   a_mode_join: assert property (p_mode_join) else $error("mode kind mismatch");
   a_points: assert property (p_points) else $error("update point mismatch");
   a_top: assert property (p_top) else $error("top value mismatch");
   a_oe_a: assert property (p_oe_a) else $error("channel A enable mismatch");
   a_oe_b: assert property (p_oe_b) else $error("channel B enable mismatch");
   a_nonpwm_a: assert property (p_nonpwm_a) else $error("non-PWM action wrong");
   a_fast_a: assert property (p_fast_a) else $error("fast PWM action wrong");
   a_top_match: assert property (p_top_match) else $error("match at top acted");
   a_phase_a: assert property (p_phase_a) else $error("phase action wrong");
   a_capture_edge: assert property (p_capture_edge) else $error("capture missed");
   a_capture_copy: assert property (p_capture_copy) else $error("capture value wrong");
endmodule // twm_mode_control_props

bind twm_mode_control twm_mode_control_props u_props (.*);

//--- tb/twm_mode_control_tb_top.sv
// Self-checking bench for the waveform mode control block
`timescale 1ns/10ps
`include "twm_defines.vh"
module twm_mode_control_tb_top;
   reg         clk           = 1'b0;
   reg         resetn        = 1'b0;
   reg         psel          = 1'b0;
   reg         penable       = 1'b0;
   reg         pwrite        = 1'b0;
   reg  [11:0] paddr         = 12'h000;
   reg  [31:0] pwdata        = 32'h0;
   reg  [15:0] counterValue  = 16'h0050;
   reg  [15:0] compareValueA = 16'h0010;
   reg  [15:0] compareValueB = 16'h0010;
   reg         matchA        = 1'b0;
   reg         matchB        = 1'b0;
   reg         countingDown  = 1'b0;
   reg         dirOutA       = 1'b1;
   reg         dirOutB       = 1'b1;
   reg         capturePin    = 1'b0;
   wire        pready, pslverr, chanAWaveOut, chanAWaveOe, chanBWaveOut, chanBWaveOe;
   wire [31:0] prdata;
   wire [15:0] topValue;
   wire [2:0]  modeKind;
   wire [1:0]  compareUpdateAt;
   wire [1:0]  overflowAt;
   wire [15:0] captureRegister;
   wire        captureFlag, captureEnabled, overflowFlag;
   wire [3:0]  wv = {chanAWaveOut, chanBWaveOut, chanAWaveOe, chanBWaveOe};
   int         bad_count  = 0;
   int         n_compared = 0;
   reg  [31:0] rdv;
   reg         err;
   reg  [15:0] cv;
   reg  [1:0]  mSeq [0:3] = '{2'd3, 2'd1, 2'd1, 2'd2};

   twm_mode_control uut (.*);

   always #10 clk = ~clk;

   task automatic check(input [31:0] got, input [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input [11:0] a, input w, input [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input [11:0] a, input [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rd(input [11:0] a, input [31:0] e);
      apb(a, 1'b0, 32'h0);
      check(rdv, e);
   endtask
   task automatic chkWave(input [3:0] e, input [3:0] k);
      check({28'h0, wv & k}, {28'h0, e});
   endtask
   task automatic pulse(input dn);
      countingDown <= dn;
      matchA       <= 1'b1;
      matchB       <= 1'b1;
      @(posedge clk);
      matchA       <= 1'b0;
      matchB       <= 1'b0;
      @(posedge clk);
   endtask
   task automatic bottom;
      counterValue <= 16'h0000;
      @(posedge clk);
      counterValue <= 16'h0050;
      @(posedge clk);
   endtask
   task automatic pinHold(input lvl, input int n);
      capturePin <= lvl;
      repeat (n) @(posedge clk);
   endtask
   function automatic [23:0] expMode(input [3:0] w, input [15:0] ca, input [15:0] cr);
      reg [15:0] fix;
      fix = (16'h0080 << w[1:0]) - 16'h0001;
      case (w)
         4'd0: expMode = {3'd0, 2'd0, 2'd3, 1'b1, 16'hffff};
         4'd1, 4'd2, 4'd3: expMode = {3'd3, 2'd1, 2'd2, 1'b1, fix};
         4'd4: expMode = {3'd1, 2'd0, 2'd3, 1'b1, ca};
         4'd8: expMode = {3'd4, 2'd2, 2'd2, 1'b0, cr};
         4'd9: expMode = {3'd4, 2'd2, 2'd2, 1'b1, ca};
         4'd10: expMode = {3'd3, 2'd1, 2'd2, 1'b0, cr};
         4'd11: expMode = {3'd3, 2'd1, 2'd2, 1'b1, ca};
         4'd12: expMode = {3'd1, 2'd0, 2'd3, 1'b0, cr};
         4'd14: expMode = {3'd2, 2'd1, 2'd1, 1'b0, cr};
         4'd15: expMode = {3'd2, 2'd1, 2'd1, 1'b1, ca};
         default: expMode = {3'd2, 2'd1, 2'd1, 1'b1, fix};
      endcase
   endfunction
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Whole run is under a thousand cycles
   initial begin
      #(20 * 5000);
      bad_count++;
      wrap_up;
   end

   initial begin
      cv = 16'($urandom(32'h64c9d8f3));
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(`TWM_ADDR_CTRL_A, 32'h0);
      rd(`TWM_ADDR_CTRL_B, 32'h0);
      check({16'h0, topValue}, 32'hffff);
      wr(`TWM_ADDR_CTRL_A, 32'hff);
      rd(`TWM_ADDR_CTRL_A, 32'hf3);
      wr(`TWM_ADDR_CTRL_B, 32'hdb);
      rd(`TWM_ADDR_CTRL_B, 32'hd8);
      apb(12'h100, 1'b0, 32'h0);
      check({31'h0, err}, 32'h1);
      $display("test registers done");
      for (int w = 0; w < 16; w++) begin
         compareValueA <= 16'($urandom);
         cv = 16'($urandom);
         wr(`TWM_ADDR_CTRL_A, {30'h0, w[1:0]});
         wr(`TWM_ADDR_CTRL_B, {27'h0, w[3:2], 3'h0});
         wr(`TWM_ADDR_CAPTURE, {16'h0, cv});
         if (w == 13) begin
            check({29'h0, modeKind}, 32'h5);
         end else begin
            check({8'h0, modeKind, compareUpdateAt, overflowAt, captureEnabled, topValue},
                  {8'h0, expMode(4'(w), compareValueA, cv)});
         end
      end
      $display("test mode table done");
      wr(`TWM_ADDR_CTRL_B, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(`TWM_ADDR_CTRL_A, {24'h0, mSeq[i], mSeq[i], 4'h0});
         pulse(1'b0);
         chkWave({{2{~i[0]}}, 2'b11}, 4'hf);
      end
      dirOutA <= 1'b0;
      wr(`TWM_ADDR_CTRL_A, 32'h80);
      chkWave(4'h0, 4'h3);
      dirOutA <= 1'b1;
      wr(`TWM_ADDR_CTRL_B, 32'h08);
      wr(`TWM_ADDR_CTRL_A, 32'h51);
      chkWave(4'h0, 4'h3);
      wr(`TWM_ADDR_CTRL_B, 32'h18);
      wr(`TWM_ADDR_CTRL_A, 32'h53);
      pulse(1'b0);
      chkWave(4'ha, 4'hb);
      wr(`TWM_ADDR_CTRL_B, 32'h08);
      wr(`TWM_ADDR_CTRL_A, 32'ha1);
      pulse(1'b0);
      chkWave(4'h3, 4'hf);
      bottom;
      chkWave(4'hf, 4'hf);
      compareValueA <= 16'h00ff;
      compareValueB <= 16'h00ff;
      pulse(1'b0);
      chkWave(4'hf, 4'hf);
      compareValueA <= 16'h0010;
      compareValueB <= 16'h0010;
      wr(`TWM_ADDR_CTRL_A, 32'hf1);
      bottom;
      chkWave(4'h3, 4'hf);
      pulse(1'b0);
      chkWave(4'hf, 4'hf);
      $display("test fast pwm done");
      wr(`TWM_ADDR_CTRL_B, 32'h0);
      wr(`TWM_ADDR_CTRL_A, 32'ha1);
      pulse(1'b0);
      chkWave(4'h3, 4'hf);
      pulse(1'b1);
      chkWave(4'hf, 4'hf);
      wr(`TWM_ADDR_CTRL_A, 32'hf1);
      pulse(1'b1);
      chkWave(4'h3, 4'hf);
      pulse(1'b0);
      chkWave(4'hf, 4'hf);
      wr(`TWM_ADDR_STATUS, 32'h2);
      bottom;
      check({31'h0, overflowFlag}, 32'h1);
      $display("test phase pwm done");
      wr(`TWM_ADDR_CTRL_A, 32'h0);
      wr(`TWM_ADDR_CTRL_B, 32'h40);
      wr(`TWM_ADDR_STATUS, 32'h1);
      cv = 16'($urandom) | 16'h0100;
      counterValue <= cv;
      pinHold(1'b1, 8);
      check({31'h0, captureFlag}, 32'h1);
      check({16'h0, captureRegister}, {16'h0, cv});
      wr(`TWM_ADDR_STATUS, 32'h1);
      pinHold(1'b0, 8);
      check({31'h0, captureFlag}, 32'h0);
      wr(`TWM_ADDR_CTRL_B, 32'h0);
      pinHold(1'b1, 8);
      check({31'h0, captureFlag}, 32'h0);
      pinHold(1'b0, 8);
      check({31'h0, captureFlag}, 32'h1);
      wr(`TWM_ADDR_CTRL_B, 32'hc0);
      wr(`TWM_ADDR_STATUS, 32'h1);
      pinHold(1'b1, 3);
      pinHold(1'b0, 10);
      check({31'h0, captureFlag}, 32'h0);
      pinHold(1'b1, 14);
      check({31'h0, captureFlag}, 32'h1);
      wr(`TWM_ADDR_CTRL_B, 32'h58);
      counterValue <= cv ^ 16'h0101;
      wr(`TWM_ADDR_STATUS, 32'h1);
      pinHold(1'b0, 10);
      pinHold(1'b1, 10);
      check({15'h0, captureFlag, captureRegister}, {16'h0, cv});
      $display("test capture done");
      wrap_up;
   end
endmodule // twm_mode_control_tb_top
